//--- pkg/pitc_pkg.sv
// Constants, control word layout and state types for the interval timer channel.
package pitc_pkg;
    // Down counter and count register width.
    localparam int CNT_W = 16;
    // Count mode codes carried in the control word.
    localparam logic [1:0] MODE_INT_END = 2'h0;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_RATE_GEN = 2'h2;
    // Read/write access codes carried in the control word.
    localparam logic [1:0] RW_LOW_ONLY = 2'h1;
    localparam logic [1:0] RW_HIGH_ONLY = 2'h2;
    localparam logic [1:0] RW_LOW_HIGH = 2'h3;
    // Counter values that steer the output and the reload.
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Decimal digit limits for the decrement.
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] DIGIT_NINE = 4'h9;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam int DIGITS = 4;
    // Reset values.
    localparam logic OUT_RST = 1'b1;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] RW_RST = 2'h1;

    // Control word as presented by the processor side.
    typedef struct packed {
        logic [1:0] rw;
        logic [1:0] mode;
        logic bcd;
    } pitc_ctrl_s;

    // Which byte of a two-byte count the next write supplies.
    typedef enum logic {
        WST_LOW,
        WST_HIGH
    } pitc_wst_e;
endpackage

//--- core/pitc_channel.sv
// One down-counter channel of an interval timer running count modes 0, 1 and 2.
// Notes on behaviour
// - Mode 0 count write drives output low immediately.
// - Mode 0 first byte halts counting, output low.
// - Gate high: load next pulse, low N+1.
// - Gate low: load anyway, decrement after gate high.
// - Mode 0 zero sets output high, keeps wrapping.
// - Mode 1 retriggers: each trigger reloads count.
// - Mode 1 trigger pulse loads and drives low.
// - Mode 1 decrements after load, N pulses low.
// - Mode 1 count write waits for next trigger.
// - Mode 1 zero returns output high, wraps.
// - Triggers ignored until full count written.
// - Mode 2 loads after first count write.
// - Mode 2 reloads on pulse after reaching one.
// - Mode 2 output low when counter decrements to one.
// - Mode 2 trigger reloads on next pulse.
// - Mode 2 gate low halts, forces output high.
// - Mode 2 count write used at reload.
// - Mode 2 never decrements to zero.
// - Gate rise sets trigger flop, cleared when sensed.
// - Decrement happens on counter clock rising edge.
// - Count zero means maximum count.
`timescale 1ns/1ps
`default_nettype none
module pitc_channel
    import pitc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Control word write, one-cycle strobe with its word.
    input wire logic cw_wr,
    input wire pitc_ctrl_s cw,
    // Count byte write, one-cycle strobe with its byte.
    input wire logic cnt_wr,
    input wire logic [7:0] cnt_byte,
    // External pins, asynchronous to mclk.
    input wire logic ext_clk_pin,
    input wire logic gate_pin,
    // Results.
    output logic cnt_out,
    output logic [CNT_W-1:0] cur_count
);

    // Decrement in binary or in four decimal digits, wrapping at zero.
    function automatic logic [CNT_W-1:0] pitc_dec(input logic [CNT_W-1:0] v, input logic bcd);
        logic [CNT_W-1:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - CNT_ONE;
        end else begin
            for (int i = 0; i < DIGITS; i++) begin
                if (borrow) begin
                    if (v[i*4+:4] == DIGIT_ZERO) begin
                        r[i*4+:4] = DIGIT_NINE;
                    end else begin
                        r[i*4+:4] = v[i*4+:4] - DIGIT_ONE;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // Synchronisers for the two pins; stage one feeds stage two only.
    logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
    logic gate_s1_reg, gate_s2_reg, gate_s3_reg;
    // Programmed mode, access and number format.
    logic [1:0] mode_reg;
    logic [1:0] rw_reg;
    logic bcd_reg;
    // Count register and the low byte held during a two-byte write.
    logic [CNT_W-1:0] count_reg;
    logic [7:0] low_byte_reg;
    pitc_wst_e wst_reg;
    // Down counter and output pin level.
    logic [CNT_W-1:0] down_reg;
    logic [CNT_W-1:0] down_next;
    logic out_reg;
    logic out_next;
    // Sequencing flags.
    logic armed_reg;
    logic hold_reg;
    logic load_reg;
    logic trig_reg;

    // Named decodes of pins and writes.
    wire pulse = clk_s2_reg & ~clk_s3_reg;
    wire gate_rise = gate_s2_reg & ~gate_s3_reg;
    wire gate_high = gate_s2_reg;
    wire two_byte = (rw_reg == RW_LOW_HIGH);
    wire first_byte = cnt_wr & ~cw_wr & two_byte & (wst_reg == WST_LOW);
    wire cnt_done = cnt_wr & ~cw_wr & ~first_byte;
    wire trig_ok = trig_reg & armed_reg & ~hold_reg;
    wire [CNT_W-1:0] dec_val = pitc_dec(down_reg, bcd_reg);
    wire dec_zero = (dec_val == CNT_ZERO);
    wire dec_one = (dec_val == CNT_ONE);
    wire at_one = (down_reg == CNT_ONE);
    wire [CNT_W-1:0] new_count = (rw_reg == RW_LOW_ONLY) ? {BYTE_ZERO, cnt_byte} :
                                 (rw_reg == RW_HIGH_ONLY) ? {cnt_byte, BYTE_ZERO} :
                                 {cnt_byte, low_byte_reg};

    // Two flip-flops per pin, then a third only for edge detection.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            // The gate idles high, so its stages reset high and no false rise follows reset.
            gate_s1_reg <= 1'b1;
            gate_s2_reg <= 1'b1;
            gate_s3_reg <= 1'b1;
        end else begin
            clk_s1_reg <= ext_clk_pin;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            gate_s1_reg <= gate_pin;
            gate_s2_reg <= gate_s1_reg;
            gate_s3_reg <= gate_s2_reg;
        end
    end

    // Control word capture; a new mode restarts the byte sequence.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= MODE_RST;
            rw_reg <= RW_RST;
            bcd_reg <= 1'b0;
        end else if (cw_wr) begin
            mode_reg <= cw.mode;
            rw_reg <= cw.rw;
            bcd_reg <= cw.bcd;
        end
    end

    // Count bytes; the count register changes only when complete, so a
    // running pulse or period is not disturbed by a half-written value.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= CNT_RST;
            low_byte_reg <= BYTE_ZERO;
            wst_reg <= WST_LOW;
        end else if (cw_wr) begin
            wst_reg <= WST_LOW;
        end else if (first_byte) begin
            low_byte_reg <= cnt_byte;
            wst_reg <= WST_HIGH;
        end else if (cnt_done) begin
            count_reg <= new_count;
            wst_reg <= WST_LOW;
        end
    end

    // Armed once a full count follows the mode set; hold spans a two-byte write.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (cw_wr) begin
            armed_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            armed_reg <= armed_reg | cnt_done;
            hold_reg <= first_byte | (hold_reg & ~cnt_done);
        end
    end

    // Pending transfer: every count write in mode 0, the first one in mode 2.
    // A write in the same cycle as the consuming pulse keeps the flag set.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_reg <= 1'b0;
        end else if (cw_wr) begin
            load_reg <= 1'b0;
        end else if (cnt_done && (mode_reg == MODE_INT_END)) begin
            load_reg <= 1'b1;
        end else if (cnt_done && (mode_reg == MODE_RATE_GEN) && !armed_reg) begin
            load_reg <= 1'b1;
        end else if (pulse && !hold_reg && (gate_high || (mode_reg != MODE_RATE_GEN))) begin
            // A gated-off rate generator keeps its first transfer pending.
            load_reg <= 1'b0;
        end
    end

    // Trigger flop: a rise wins over the clear by the sensing pulse.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= gate_rise | (trig_reg & ~pulse);
        end
    end

    // Counter and output next state per mode; a control word write, or a count byte in mode 0, overrides the pulse's pin level.
    always_comb begin
        down_next = down_reg;
        out_next = out_reg;
        unique case (mode_reg)
            MODE_INT_END: begin
                // The counter stalls while a two-byte count is half written.
                if (pulse && !hold_reg) begin
                    if (load_reg) begin
                        down_next = count_reg;
                    end else if (gate_high) begin
                        down_next = dec_val;
                        if (dec_zero) begin
                            out_next = 1'b1;
                        end
                    end
                end
                // Any count byte forces the pin low with no counter clock.
                if (cnt_wr) begin
                    out_next = 1'b0;
                end
            end
            MODE_ONE_SHOT: begin
                if (pulse) begin
                    if (trig_ok) begin
                        down_next = count_reg;
                        out_next = 1'b0;
                    end else begin
                        down_next = dec_val;
                        if (dec_zero) begin
                            out_next = 1'b1;
                        end
                    end
                end
            end
            MODE_RATE_GEN: begin
                // Gate low freezes the counter and releases a low pin at once.
                if (!gate_high) begin
                    out_next = 1'b1;
                end else if (pulse && armed_reg) begin
                    if (load_reg || trig_ok || at_one) begin
                        // Reloading from one is what keeps zero unreachable.
                        down_next = count_reg;
                        out_next = 1'b1;
                    end else begin
                        down_next = dec_val;
                        if (dec_one) begin
                            out_next = 1'b0;
                        end
                    end
                end
            end
            default: begin
                // Modes beyond 2 are not built here; the channel idles high.
                out_next = 1'b1;
            end
        endcase
        // A new mode sets the initial pin level; the counter keeps its current value.
        if (cw_wr) begin
            out_next = (cw.mode != MODE_INT_END);
        end
    end

    // State registers of the counter and the pin.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            down_reg <= CNT_RST;
            out_reg <= OUT_RST;
        end else begin
            down_reg <= down_next;
            out_reg <= out_next;
        end
    end

    // Software must keep counts at or above the mode minimum; one in mode 2
    // would hold the pin high forever since the reload lands on one itself.
    assign cnt_out = out_reg;
    assign cur_count = down_reg;

    // A complete mode 0 count write, which must leave a transfer pending.
    sequence s_m0_write;
        cnt_done && !cw_wr && (mode_reg == MODE_INT_END);
    endsequence

    // The pulse that carries out a pending mode 0 transfer.
    sequence s_m0_transfer;
        pulse && load_reg && !hold_reg && !cnt_wr && !cw_wr && (mode_reg == MODE_INT_END);
    endsequence

    AST_M0_WRITE_LOW: assert property (@(posedge mclk) disable iff (!resetn)
        cnt_wr && !cw_wr && (mode_reg == MODE_INT_END) |=> !cnt_out)
        else $error("Mode 0 count write did not drive the output low.");

    AST_M0_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        hold_reg && !cw_wr && (mode_reg == MODE_INT_END) |=> $stable(cur_count) && !cnt_out)
        else $error("Mode 0 counter moved while a count was half written.");

    AST_M0_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
        s_m0_transfer |=> (cur_count == $past(count_reg)) && !cnt_out)
        else $error("Mode 0 count was not transferred on the pending pulse.");

    AST_M0_PENDING: assert property (@(posedge mclk) disable iff (!resetn)
        s_m0_write |=> load_reg)
        else $error("Mode 0 count write did not leave a transfer pending.");

    AST_M0_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_reg == MODE_INT_END) && !cw_wr && $rose(cnt_out) |-> (cur_count == CNT_ZERO))
        else $error("Mode 0 output rose without the counter at zero.");

    AST_M1_TRIGGER: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_reg == MODE_ONE_SHOT) && pulse && trig_ok && !cw_wr
        |=> (cur_count == $past(count_reg)) && !cnt_out)
        else $error("Mode 1 trigger did not load the count and start the pulse.");

    AST_M1_IGNORE: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_reg == MODE_ONE_SHOT) && pulse && !armed_reg && !cw_wr && !cnt_wr
        |=> (cur_count == $past(dec_val)))
        else $error("Mode 1 trigger acted before a full count was written.");

    AST_M2_RELOAD: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_reg == MODE_RATE_GEN) && armed_reg && gate_high && pulse && at_one && !cw_wr
        |=> (cur_count == $past(count_reg)) && cnt_out)
        else $error("Mode 2 did not reload after the counter held one.");

    AST_M2_LOW_AT_ONE: assert property (@(posedge mclk) disable iff (!resetn)
        // The gate is taken one cycle back: in the cycle it falls the pin is still low.
        (mode_reg == MODE_RATE_GEN) && !cnt_out |-> at_one && $past(gate_high))
        else $error("Mode 2 output low with the counter away from one.");

    AST_M2_GATE_LOW: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_reg == MODE_RATE_GEN) && !gate_high && !cw_wr |=> cnt_out && $stable(cur_count))
        else $error("Mode 2 gate low did not halt the counter with the output high.");

    AST_TRIG_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
        pulse && !gate_rise |=> !trig_reg)
        else $error("Trigger flop not cleared after the sensing pulse.");

    AST_MODE_INIT: assert property (@(posedge mclk) disable iff (!resetn)
        cw_wr |=> (cnt_out == (mode_reg != MODE_INT_END)))
        else $error("Mode set did not give the initial output level.");

endmodule
`default_nettype wire

//--- tb/pitc_host_model.sv
// Behavioural processor bus and pin source that drives the timer channel.
`timescale 1ns/1ps
`default_nettype none
module pitc_host_model
    import pitc_pkg::*;
(
    // Requests from the bench, changed at the falling edge of the clock.
    input wire logic req_cw,
    input wire pitc_ctrl_s req_ctrl,
    input wire logic req_cnt,
    input wire logic [7:0] req_byte,
    input wire logic req_clk,
    input wire logic req_gate,
    // Write port towards the channel.
    output logic cw_wr,
    output var pitc_ctrl_s cw,
    output logic cnt_wr,
    output logic [7:0] cnt_byte,
    // Counter clock and hold/trigger pins.
    output logic ext_clk_pin,
    output logic gate_pin
);
    // Strobes pass straight through; a released word or byte shows its inverse,
    // so a channel that samples late never sees stale data that happens to match.
    assign cw_wr = req_cw;
    assign cw = req_cw ? req_ctrl : pitc_ctrl_s'(~req_ctrl);
    assign cnt_wr = req_cnt;
    assign cnt_byte = req_cnt ? req_byte : ~req_byte;
    // The counter clock stands low between pulses; the gate idles high.
    assign ext_clk_pin = req_clk;
    assign gate_pin = req_gate;
endmodule
`default_nettype wire

//--- tb/pitc_channel_tb.sv
// Self-checking testbench for the interval timer channel in modes 0, 1 and 2.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module pitc_channel_tb;
    import pitc_pkg::*;
    // Clock, reset and channel wiring.
    logic mclk;
    logic resetn;
    logic cw_wr;
    pitc_ctrl_s cw;
    logic cnt_wr;
    logic [7:0] cnt_byte;
    logic ext_clk_pin;
    logic gate_pin;
    logic cnt_out;
    logic [CNT_W-1:0] cur_count;
    // Requests from the bench to the partner, changed at the falling edge.
    logic req_cw;
    pitc_ctrl_s req_ctrl;
    logic req_cnt;
    logic [7:0] req_byte;
    logic req_clk;
    logic req_gate;
    // Mismatch and comparison counters.
    int err_count;
    int n_compared;

    pitc_channel i_pitc_channel (.mclk(mclk), .resetn(resetn), .cw_wr(cw_wr), .cw(cw),
        .cnt_wr(cnt_wr), .cnt_byte(cnt_byte), .ext_clk_pin(ext_clk_pin),
        .gate_pin(gate_pin), .cnt_out(cnt_out), .cur_count(cur_count));
    pitc_host_model i_pitc_host_model (.req_cw(req_cw), .req_ctrl(req_ctrl),
        .req_cnt(req_cnt), .req_byte(req_byte), .req_clk(req_clk), .req_gate(req_gate),
        .cw_wr(cw_wr), .cw(cw), .cnt_wr(cnt_wr), .cnt_byte(cnt_byte),
        .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin));

    // 125 MHz clock.
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    // Idle requests: no strobe, counter clock still low, gate high.
    initial begin
        req_cw = 1'h0;
        req_ctrl = '0;
        req_cnt = 1'h0;
        req_byte = 8'h00;
        req_clk = 1'h0;
        req_gate = 1'h1;
    end

    // Compares the output level and the counter value together.
    task automatic st(input logic o, input logic [CNT_W-1:0] c);
        `CHK(cnt_out, o)
        `CHK(cur_count, c)
    endtask

    // Control word write: one strobe cycle, then one cycle for the effect to land.
    task automatic wr_cw(input logic [1:0] rw, input logic [1:0] mode, input logic bcd);
        @(negedge mclk);
        req_cw = 1'h1;
        req_ctrl = '{rw: rw, mode: mode, bcd: bcd};
        @(negedge mclk);
        req_cw = 1'h0;
        @(negedge mclk);
    endtask

    // Count byte write; the partner shows the inverse once the strobe drops.
    task automatic wr_cnt(input logic [7:0] b);
        @(negedge mclk);
        req_cnt = 1'h1;
        req_byte = b;
        @(negedge mclk);
        req_cnt = 1'h0;
        @(negedge mclk);
    endtask

    // One counter clock pulse, high and low long enough for the synchronisers.
    task automatic p();
        req_clk = 1'h1;
        repeat (4) @(negedge mclk);
        req_clk = 1'h0;
        repeat (4) @(negedge mclk);
    endtask

    // Gate level change, held until the synchronised edge has been seen.
    task automatic g(input logic v);
        req_gate = v;
        repeat (5) @(negedge mclk);
    endtask

    // Mode 0, gate high: load on the first pulse, low for N+1 pulses, then wrap.
    task automatic sc_m0_gate_high();
        wr_cw(RW_LOW_ONLY, MODE_INT_END, 1'h0);
        `CHK(cnt_out, 1'h0)
        wr_cnt(8'h03);
        `CHK(cnt_out, 1'h0)
        p();
        st(1'h0, 16'h0003);
        p();
        p();
        st(1'h0, 16'h0001);
        p();
        st(1'h1, 16'h0000);
        p();
        st(1'h1, 16'hFFFF);
    endtask

    // Mode 0, decimal, gate low at the write: load anyway, count only with gate high.
    task automatic sc_m0_gate_low_bcd();
        wr_cw(RW_LOW_ONLY, MODE_INT_END, 1'h1);
        g(1'h0);
        wr_cnt(8'h02);
        p();
        st(1'h0, 16'h0002);
        p();
        st(1'h0, 16'h0002);
        g(1'h1);
        p();
        st(1'h0, 16'h0001);
        p();
        st(1'h1, 16'h0000);
        p();
        st(1'h1, 16'h9999);
    endtask

    // Mode 0, two-byte: the first byte drops the output and halts counting.
    task automatic sc_m0_two_byte();
        wr_cw(RW_LOW_HIGH, MODE_INT_END, 1'h0);
        wr_cnt(8'h01);
        wr_cnt(8'h00);
        p();
        p();
        st(1'h1, 16'h0000);
        wr_cnt(8'h02);
        `CHK(cnt_out, 1'h0)
        p();
        st(1'h0, 16'h0000);
        wr_cnt(8'h00);
        p();
        st(1'h0, 16'h0002);
    endtask

    // A count of zero is the largest count; then a high-only byte and the idle mode code.
    task automatic sc_max_count();
        wr_cw(RW_LOW_ONLY, MODE_INT_END, 1'h0);
        wr_cnt(8'h00);
        p();
        p();
        st(1'h0, 16'hFFFF);
        wr_cw(RW_HIGH_ONLY, MODE_INT_END, 1'h0);
        wr_cnt(8'h01);
        p();
        st(1'h0, 16'h0100);
        wr_cw(RW_LOW_ONLY, 2'h3, 1'h0);
        `CHK(cnt_out, 1'h1)
    endtask

    // Mode 1: unarmed trigger ignored, retrigger reloads a count written mid-pulse.
    task automatic sc_m1_one_shot();
        int i;
        wr_cw(RW_LOW_ONLY, MODE_ONE_SHOT, 1'h0);
        `CHK(cnt_out, 1'h1)
        g(1'h0);
        g(1'h1);
        p();
        `CHK(cnt_out, 1'h1)
        g(1'h0);
        wr_cnt(8'h03);
        g(1'h1);
        p();
        st(1'h0, 16'h0003);
        p();
        wr_cnt(8'h05);
        p();
        st(1'h0, 16'h0001);
        g(1'h0);
        g(1'h1);
        p();
        st(1'h0, 16'h0005);
        for (i = 4; i >= 1; i--) begin
            p();
            st(1'h0, 16'(i));
        end
        p();
        st(1'h1, 16'h0000);
        p();
        st(1'h1, 16'hFFFF);
        // Armed by a full two-byte count, then a lone first byte blocks the trigger.
        wr_cw(RW_LOW_HIGH, MODE_ONE_SHOT, 1'h0);
        wr_cnt(8'h02);
        wr_cnt(8'h00);
        wr_cnt(8'h07);
        g(1'h0);
        g(1'h1);
        p();
        st(1'h1, 16'hFFFE);
        wr_cnt(8'h00);
    endtask

    // Mode 2: one-clock low at one, reload, gate hold and trigger restart.
    task automatic sc_m2_rate();
        wr_cw(RW_LOW_ONLY, MODE_RATE_GEN, 1'h0);
        `CHK(cnt_out, 1'h1)
        wr_cnt(8'h03);
        p();
        st(1'h1, 16'h0003);
        p();
        wr_cnt(8'h04);
        p();
        st(1'h0, 16'h0001);
        p();
        st(1'h1, 16'h0004);
        p();
        p();
        p();
        st(1'h0, 16'h0001);
        g(1'h0);
        `CHK(cnt_out, 1'h1)
        p();
        st(1'h1, 16'h0001);
        g(1'h1);
        p();
        st(1'h1, 16'h0004);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset for four cycles, then each scenario in turn.
    initial begin
        err_count = 0;
        n_compared = 0;
        resetn = 1'h0;
        repeat (4) @(negedge mclk);
        resetn = 1'h1;
        @(negedge mclk);
        st(OUT_RST, CNT_RST);
        sc_m0_gate_high();
        sc_m0_gate_low_bcd();
        sc_m0_two_byte();
        sc_max_count();
        sc_m1_one_shot();
        sc_m2_rate();
        final_report();
    end

    // Bounded run: a hang counts as a mismatch and goes to the report.
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
